/* hdl/rxp_exec.sv */
/*
  Execution unit for the accumulator/RAM exchange instructions with X xor and Y step.
  Assumes the sequencer presents one decoded operation per cycle with op_valid,
  and the RAM returns the addressed nibble combinationally on mem_rdata.
*/
// How it works
// - The decrement variant lowers Y by one, wrapping modulo sixteen, and writes it back.
// - After a decrement that leaves Y at fifteen, the next instruction is skipped.
// - When the stepped Y misses its skip value, the next instruction runs normally.
// - The increment variant swaps the accumulator with the RAM nibble at the address pointer in one cycle.
// - Register X is xored with the 4-bit immediate and the result is written back to X.
// - The increment variant adds one to Y modulo sixteen and writes it back.
// - After an increment that leaves Y at zero, the next instruction is skipped.
`timescale 1ns/10ps
`default_nettype none
module rxp_exec (
  input  wire logic                  clk,
  input  wire logic                  rst_b,
  input  wire logic                  op_valid,
  input  wire rxp_pkg::rxp_op_t      op_code,
  input  wire logic [3:0]            op_imm,
  input  wire logic [7:0]            ram_address_pointer,
  input  wire logic [3:0]            mem_rdata,
  output logic      [7:0]            mem_addr,
  output logic      [3:0]            mem_wdata,
  output logic                       mem_we,
  output logic      [3:0]            acc_q,
  output logic      [3:0]            x_q,
  output logic      [3:0]            y_q,
  output logic                       skip_active,
  output logic                       op_done
);
  // ==========================================================
  // Architectural state and its next values
  // The registers themselves, except state_reg, are rxp_nib_reg cells further down
  rxp_pkg::rxp_state_t state_reg;
  rxp_pkg::rxp_state_t state_next;
  logic [3:0]          acc_reg;
  logic [3:0]          acc_next;
  logic                acc_load;
  logic [3:0]          x_reg;
  logic [3:0]          x_next;
  logic                x_load;
  logic [3:0]          y_reg;
  logic [3:0]          y_next;
  logic                y_load;
  logic                done_reg;
  logic                done_next;

  // ==========================================================
  // Decode of the presented word
  logic                is_inc;
  logic                is_dec;
  logic                is_step;
  logic                in_skip;
  logic                exec_ok;
  logic                swallow;

  assign is_inc  = op_code == rxp_pkg::RXP_OP_INC;
  assign is_dec  = op_code == rxp_pkg::RXP_OP_DEC;
  // The spare fourth code is neither step, so it falls through like NONE
  assign is_step = is_inc || is_dec;
  assign in_skip = state_reg == rxp_pkg::RXP_ST_SKIP;
  // A skipped slot still consumes the fetched word but commits nothing
  assign exec_ok = op_valid && is_step && !in_skip;
  // Any word in the skip slot is swallowed, whatever its code
  assign swallow = op_valid && in_skip;

  // ==========================================================
  // Pointer step and skip test
  logic [3:0]          y_inc;
  logic [3:0]          y_dec;
  logic                inc_hit;
  logic                dec_hit;
  logic                skip_hit;

  // Four-bit sums wrap modulo sixteen by width alone, no carry is kept
  assign y_inc    = y_reg + rxp_pkg::Y_STEP;
  assign y_dec    = y_reg - rxp_pkg::Y_STEP;
  assign y_next   = is_inc ? y_inc : y_dec;
  assign inc_hit  = y_inc == rxp_pkg::INC_SKIP;
  assign dec_hit  = y_dec == rxp_pkg::DEC_SKIP;
  // A miss leaves the sequencer in RUN, so the next word executes
  assign skip_hit = is_inc ? inc_hit : dec_hit;

  // ==========================================================
  // RAM side
  // The address is not registered: the nibble read for the swap and the
  // nibble written back are the same one, within a single cycle
  assign mem_addr  = ram_address_pointer;
  assign mem_wdata = acc_reg;
  assign mem_we    = exec_ok && is_inc;

  // ==========================================================
  // Skip sequencing
  // The skip is a state, not a count: one word goes, however late it comes
  always_comb begin
    state_next = state_reg;
    case (state_reg)
      rxp_pkg::RXP_ST_RUN: begin
        if (exec_ok && skip_hit) begin
          state_next = rxp_pkg::RXP_ST_SKIP;
        end
      end
      rxp_pkg::RXP_ST_SKIP: begin
        // Any fetched word, recognised or not, is the one swallowed
        if (swallow) begin
          state_next = rxp_pkg::RXP_ST_RUN;
        end
      end
      default: begin
        state_next = rxp_pkg::RXP_ST_RUN;
      end
    endcase
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      state_reg <= rxp_pkg::RXP_ST_RUN;
    end else begin
      state_reg <= state_next;
    end
  end

  // ==========================================================
  // Register loads
  // Only the increment variant exchanges; the decrement keeps the accumulator
  assign acc_load  = exec_ok && is_inc;
  assign acc_next  = mem_rdata;
  assign x_load    = exec_ok;
  assign x_next    = x_reg ^ op_imm;
  assign y_load    = exec_ok;
  assign done_next = exec_ok;

  // ==========================================================
  // Register cells
  // One shared cell keeps the reset behaviour of every register except state_reg alike
  rxp_nib_reg #(
    .WIDTH (rxp_pkg::NIB_W),
    .RST   (rxp_pkg::ACC_RST)
  ) u_acc (
    .clk   (clk),
    .rst_b (rst_b),
    .load  (acc_load),
    .d     (acc_next),
    .q     (acc_reg)
  );

  rxp_nib_reg #(
    .WIDTH (rxp_pkg::NIB_W),
    .RST   (rxp_pkg::X_RST)
  ) u_x (
    .clk   (clk),
    .rst_b (rst_b),
    .load  (x_load),
    .d     (x_next),
    .q     (x_reg)
  );

  rxp_nib_reg #(
    .WIDTH (rxp_pkg::NIB_W),
    .RST   (rxp_pkg::Y_RST)
  ) u_y (
    .clk   (clk),
    .rst_b (rst_b),
    .load  (y_load),
    .d     (y_next),
    .q     (y_reg)
  );

  rxp_nib_reg #(
    .WIDTH (1),
    .RST   (rxp_pkg::DONE_RST)
  ) u_done (
    .clk   (clk),
    .rst_b (rst_b),
    .load  (1'b1),
    .d     (done_next),
    .q     (done_reg)
  );

  // ==========================================================
  // Outputs
  // Data outputs come straight from register cells
  assign acc_q       = acc_reg;
  assign x_q         = x_reg;
  assign y_q         = y_reg;
  assign skip_active = in_skip;
  assign op_done     = done_reg;
endmodule : rxp_exec

// ==========================================================
// Register cell
// Plain load-enabled register; the reset value is a constant parameter, so
// the asynchronous branch never loads anything but a constant
module rxp_nib_reg #(
  parameter int unsigned      WIDTH = 4,
  parameter logic [WIDTH-1:0] RST   = '0
) (
  input  wire logic             clk,
  input  wire logic             rst_b,
  input  wire logic             load,
  input  wire logic [WIDTH-1:0] d,
  output logic      [WIDTH-1:0] q
);
  logic [WIDTH-1:0] q_reg;

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      q_reg <= RST;
    end else if (load) begin
      q_reg <= d;
    end
  end

  assign q = q_reg;
endmodule : rxp_nib_reg

`default_nettype wire

/* hdl/rxp_pkg.sv */
/*
  Constants for the RAM exchange / pointer step execution unit.
  Assumes a 4-bit datapath and a sequencer that issues one operation per cycle.
*/
`default_nettype none
package rxp_pkg;
  localparam int unsigned NIB_W     = 4;
  localparam int unsigned RAM_AW    = 8;
  localparam logic [3:0]  Y_STEP    = 4'h1;
  localparam logic [3:0]  DEC_SKIP  = 4'hf;
  localparam logic [3:0]  INC_SKIP  = 4'h0;
  localparam logic [3:0]  ACC_RST   = 4'h0;
  localparam logic [3:0]  X_RST     = 4'h0;
  localparam logic [3:0]  Y_RST     = 4'h0;
  localparam logic        DONE_RST  = 1'b0;

  typedef enum logic [1:0] {
    RXP_OP_NONE,
    RXP_OP_INC,
    RXP_OP_DEC
  } rxp_op_t;

  typedef enum {
    RXP_ST_RUN,
    RXP_ST_SKIP
  } rxp_state_t;
endpackage : rxp_pkg
`default_nettype wire

/* test/rxp_exec_chk.sv */
/* Assertions on rxp_exec ports; bound to every instance of it */
`timescale 1ns/10ps
`default_nettype none
module rxp_exec_chk (
  input  wire logic             clk,
  input  wire logic             rst_b,
  input  wire logic             op_valid,
  input  wire rxp_pkg::rxp_op_t op_code,
  input  wire logic [3:0]       op_imm,
  input  wire logic [7:0]       ram_address_pointer,
  input  wire logic [3:0]       mem_rdata,
  input  wire logic [7:0]       mem_addr,
  input  wire logic [3:0]       mem_wdata,
  input  wire logic             mem_we,
  input  wire logic [3:0]       acc_q,
  input  wire logic [3:0]       x_q,
  input  wire logic [3:0]       y_q,
  input  wire logic             skip_active,
  input  wire logic             op_done
);
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_b);
  wire go = op_valid && !skip_active && op_code != rxp_pkg::RXP_OP_NONE;
  wire inc = go && op_code == rxp_pkg::RXP_OP_INC;
  wire dec = go && op_code == rxp_pkg::RXP_OP_DEC;
  y_dec_a: assert property (dec |=> y_q == $past(y_q) - 4'h1) else $error("y decrement wrong");
  dec_skip_a: assert property (dec |=> skip_active == (y_q == 4'hf)) else $error("skip after dec wrong");
  swap_a: assert property (inc |-> mem_we ##1 acc_q == $past(mem_rdata)) else $error("swap wrong");
  xor_x_a: assert property (go |=> x_q == ($past(x_q) ^ $past(op_imm))) else $error("x xor wrong");
  y_inc_a: assert property (inc |=> y_q == $past(y_q) + 4'h1) else $error("y increment wrong");
  inc_skip_a: assert property (inc |=> skip_active == (y_q == 4'h0)) else $error("skip after inc wrong");
  skip_nop_a: assert property (skip_active && op_valid |-> !mem_we ##1 $stable(acc_q) && $stable(x_q)
    && $stable(y_q) && !op_done && !skip_active) else $error("skipped word had effect");
  done_a: assert property (go |=> op_done) else $error("op_done missing");
  done_only_a: assert property (!go |=> !op_done) else $error("op_done without a step");
  addr_follow_a: assert property (mem_addr == ram_address_pointer) else $error("address off pointer");
  old_acc_out_a: assert property (mem_we |-> mem_wdata == acc_q) else $error("write data not acc");
  we_only_inc_a: assert property (mem_we |-> inc) else $error("write without increment");
  dec_keep_acc_a: assert property (dec |=> $stable(acc_q)) else $error("acc changed on decrement");
endmodule : rxp_exec_chk
bind rxp_exec rxp_exec_chk u_chk (
  .clk                 (clk),
  .rst_b               (rst_b),
  .op_valid            (op_valid),
  .op_code             (op_code),
  .op_imm              (op_imm),
  .ram_address_pointer (ram_address_pointer),
  .mem_rdata           (mem_rdata),
  .mem_addr            (mem_addr),
  .mem_wdata           (mem_wdata),
  .mem_we              (mem_we),
  .acc_q               (acc_q),
  .x_q                 (x_q),
  .y_q                 (y_q),
  .skip_active         (skip_active),
  .op_done             (op_done)
);
`default_nettype wire

/* test/rxp_ram_model.sv */
/*
  RAM nibble array for rxp_exec; combinational read, write at the clock edge.
  Assumes the unit holds address, data and write enable across the writing edge.
*/
`timescale 1ns/10ps
`default_nettype none
module rxp_ram_model (
  input  wire logic       clk,
  input  wire logic [7:0] mem_addr,
  input  wire logic [3:0] mem_wdata,
  input  wire logic       mem_we,
  output logic      [3:0] mem_rdata
);
  logic [3:0] mem [256];
  initial foreach (mem[i]) mem[i] = i[3:0] ^ 4'ha;
  assign mem_rdata = mem[mem_addr];
  always @(posedge clk) if (mem_we) mem[mem_addr] <= mem_wdata;
endmodule : rxp_ram_model
`default_nettype wire

/* test/tb_top.sv */
/* Self-checking bench for rxp_exec with the RAM model on its memory side */
`timescale 1ns/10ps
`default_nettype none
module tb_top;
  logic clk = 0, rst_b = 0, op_valid = 0, mem_we, skip_active, op_done;
  rxp_pkg::rxp_op_t op_code = rxp_pkg::RXP_OP_NONE;
  logic [3:0] op_imm = 4'h0, mem_rdata, mem_wdata, acc_q, x_q, y_q;
  logic [7:0] ptr = 8'h05, mem_addr;
  int n_errors = 0, comparisons = 0;
  always #10 clk = ~clk;
  rxp_exec i_dut(.clk(clk), .rst_b(rst_b), .op_valid(op_valid), .op_code(op_code), .op_imm(op_imm),
    .ram_address_pointer(ptr), .mem_rdata(mem_rdata), .mem_addr(mem_addr), .mem_wdata(mem_wdata),
    .mem_we(mem_we), .acc_q(acc_q), .x_q(x_q), .y_q(y_q), .skip_active(skip_active), .op_done(op_done));
  rxp_ram_model i_ram(.clk(clk), .mem_addr(mem_addr), .mem_wdata(mem_wdata), .mem_we(mem_we), .mem_rdata(mem_rdata));
  // ==========================================================
  // Compare and drive helpers
  task check(string nm, logic [7:0] seen, logic [7:0] exp);
    comparisons++;
    if (seen !== exp) begin
      n_errors++;
      $display("wrong value %s expected %h seen %h", nm, exp, seen);
    end
  endtask : check
  task op(rxp_pkg::rxp_op_t c, logic [3:0] j);
    @(posedge clk);
    op_valid <= 1'b1;
    op_code  <= c;
    op_imm   <= j;
  endtask : op
  task idle;
    @(posedge clk);
    op_valid <= 1'b0;
    #1;
  endtask : idle
  // ==========================================================
  // Scenarios
  task s_inc;
    op(rxp_pkg::RXP_OP_INC, 4'h3);
    idle;
    check("acc", acc_q, 4'hf);
    check("ram", i_ram.mem[5], 4'h0);
    check("x", x_q, 4'h3);
    check("y", y_q, 4'h1);
    check("skip", skip_active, 1'b0);
  endtask : s_inc
  task s_dec;
    op(rxp_pkg::RXP_OP_DEC, 4'h5);
    op(rxp_pkg::RXP_OP_DEC, 4'h6);
    op(rxp_pkg::RXP_OP_INC, 4'h9);
    idle;
    check("y", y_q, 4'hf);
    check("x", x_q, 4'h0);
    check("acc", acc_q, 4'hf);
    check("ram", i_ram.mem[5], 4'h0);
  endtask : s_dec
  task s_wrap;
    op(rxp_pkg::RXP_OP_INC, 4'h1);
    op(rxp_pkg::RXP_OP_INC, 4'h2);
    op(rxp_pkg::RXP_OP_DEC, 4'h4);
    idle;
    check("acc", acc_q, 4'h0);
    check("ram", i_ram.mem[5], 4'hf);
    check("x", x_q, 4'h5);
    check("y", y_q, 4'hf);
    check("skip", skip_active, 1'b1);
  endtask : s_wrap
  // Skip left over from s_wrap swallows the first word; NONE is then ignored
  task s_ram_side;
    op(rxp_pkg::RXP_OP_NONE, 4'hc);
    op(rxp_pkg::RXP_OP_NONE, 4'hc);
    ptr <= 8'h20;
    op(rxp_pkg::RXP_OP_INC, 4'h7);
    #1;
    check("we", mem_we, 1'b1);
    check("addr", mem_addr, 8'h20);
    check("wdata", mem_wdata, 4'h0);
    check("x", x_q, 4'h5);
    check("skip", skip_active, 1'b0);
    idle;
    check("done", op_done, 1'b1);
    check("acc", acc_q, 4'ha);
    check("ram", i_ram.mem[8'h20], 4'h0);
    check("x", x_q, 4'h2);
    check("y", y_q, 4'h0);
    check("skip", skip_active, 1'b1);
    op(rxp_pkg::RXP_OP_DEC, 4'h1);
    idle;
    check("done", op_done, 1'b0);
    check("y", y_q, 4'h0);
    check("skip", skip_active, 1'b0);
  endtask : s_ram_side
  // Reset in mid-run, then a first step right after release
  task s_reset;
    @(posedge clk);
    rst_b <= 1'b0;
    ptr   <= 8'h05;
    #1;
    check("acc", acc_q, 4'h0);
    check("x", x_q, 4'h0);
    check("y", y_q, 4'h0);
    check("skip", skip_active, 1'b0);
    check("done", op_done, 1'b0);
    repeat (2) @(posedge clk);
    rst_b <= 1'b1;
    op(rxp_pkg::RXP_OP_INC, 4'h6);
    idle;
    check("acc", acc_q, 4'hf);
    check("ram", i_ram.mem[5], 4'h0);
    check("x", x_q, 4'h6);
    check("y", y_q, 4'h1);
    check("skip", skip_active, 1'b0);
  endtask : s_reset
  task conclude;
    $display("errors %0d comparisons %0d", n_errors, comparisons);
    if (n_errors == 0 && comparisons > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask : conclude
  initial begin
    repeat (2) @(posedge clk);
    rst_b <= 1'b1;
    s_inc;
    s_dec;
    s_wrap;
    s_ram_side;
    s_reset;
    conclude;
  end
endmodule : tb_top
`default_nettype wire
